// >>> hdl/mtype_defs.svh
`ifndef MTYPE_DEFS_SVH
`define MTYPE_DEFS_SVH
`define MT_REG_CAP 8'h00
`define MT_REG_DEFTYPE 8'h04
`define MT_REG_FIXED 8'h08
`define MT_REG_LAST 8'h0C
`define MT_REG_VAR 8'h20
`define MT_VAR_STRIDE 8'h08
`define MT_VAR_MASK_OFS 8'h04
`define MT_DEF_EN_BIT 11
`define MT_DEF_FIXEN_BIT 10
`define MT_MASK_VALID_BIT 11
`define MT_CAP_VAR_LSB 8
`define MT_DEFTYPE_RESET 32'h0000_0000
`define MT_FIXED_RESET 32'h0000_0000
`define MT_VAR_RESET 32'h0000_0000
`define MT_FIXED_LIMIT_LSB 20
`define MT_FIXED_SEL_LSB 17
`define MT_PAGE_LSB 12
`define PTE_PAT4K_BIT 7
`define PTE_PATBIG_BIT 12
`define PTE_PCD_BIT 4
`define PTE_PWT_BIT 3
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// >>> hdl/mtype_pkg.sv
package mtype_pkg;
	// One encoding for attribute entries, range types and the result.
	typedef enum logic [2:0] {
		MT_UC = 3'h0,
		MT_WC = 3'h1,
		MT_WT = 3'h4,
		MT_WP = 3'h5,
		MT_WB = 3'h6,
		MT_UCM = 3'h7
	} mem_type_t;
	typedef enum logic [1:0] {
		ACC_CTX = 2'h0,
		ACC_PASID_TBL = 2'h1,
		ACC_STRUCT = 2'h2,
		ACC_PAGE = 2'h3
	} access_kind_t;
	typedef struct packed {
		logic inDomain;
		logic cacheDisable;
		logic [31:0] page_attr_table;
		access_kind_t kind;
		logic [63:0] entry;
		logic largePage;
		logic [31:0] physAddr;
	} req_t;
	typedef struct packed {
		logic applies;
		mem_type_t memType;
	} resp_t;
	typedef enum logic [1:0] {
		WR_COLLECT = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;
	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_DATA = 2'b10
	} rd_state_t;
endpackage

// >>> hdl/first_level_memory_type_resolver.sv
`include "mtype_defs.svh"
// Behaviour
// - Accesses from outside the coherency domain get no memory type.
// - Cache disable set in the context forces UC on every access.
// - Root and context entry fetches use UC.
// - PASID-table entry fetches use the range type alone.
// - Paging entries and page combine attribute and range types.
// - Attribute table is eight 4-bit entries, entry i at bits 4i+3:4i.
// - Attribute index bit is bit 7 for 4K pages, bit 12 for larger.
// - Cache-off bit is bit 4, write-through bit is bit 3.
// - Top-level entry fetch index is 2*cacheoff+writethrough from PASID entry.
// - Lower entry fetch index uses the same bits of the pointing entry.
// - Page access index adds four times the index bit from the mapping entry.
// - Range registers exist only when typing support is reported.
// - Range typing disabled gives UC for every address.
// - Below 1 MByte with fixed ranges enabled, use the fixed range type.
// - Exactly one variable match gives that range's type.
// - Several matches of one common type give that type.
// - Overlap with UC gives UC; WT with WB gives WT.
// - No match gives the programmed default type.
// - Range UC and WC combine with attribute per the matrix.
// - Range WT and WB combine with attribute per the matrix.
// - Range WP combines with attribute per the matrix.
// - Typing bits come from the walker, which may serve them from caches.
module first_level_memory_type_resolver #(
	parameter int NVAR = 4,
	parameter bit TYPING_SUPPORT = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Resolve request and answer
	input wire logic reqValid,
	input wire mtype_pkg::req_t req,
	output logic respValid,
	output mtype_pkg::resp_t resp,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	typedef logic [31:0] word_t;

	function automatic mtype_pkg::mem_type_t toType(input logic [2:0] v);
		mtype_pkg::mem_type_t t;
		case (v)
			3'h1: t = mtype_pkg::MT_WC;
			3'h4: t = mtype_pkg::MT_WT;
			3'h5: t = mtype_pkg::MT_WP;
			3'h6: t = mtype_pkg::MT_WB;
			3'h7: t = mtype_pkg::MT_UCM;
			default: t = mtype_pkg::MT_UC;
		endcase
		return t;
	endfunction

	function automatic mtype_pkg::mem_type_t patType(input word_t page_attr_table, input logic [2:0] i);
		logic [3:0] e;
		e = page_attr_table[{i, 2'b00} +: 4];
		return toType(e[2:0]);
	endfunction

	// Effective type from the range type r and attribute type p.
	function automatic mtype_pkg::mem_type_t effType(input mtype_pkg::mem_type_t r,
		input mtype_pkg::mem_type_t p);
		mtype_pkg::mem_type_t t;
		t = mtype_pkg::MT_UC;
		case (r)
			mtype_pkg::MT_UC: t = (p == mtype_pkg::MT_WC) ? mtype_pkg::MT_WC : mtype_pkg::MT_UC;
			mtype_pkg::MT_WC:
			begin
				if (p == mtype_pkg::MT_UCM || p == mtype_pkg::MT_WC || p == mtype_pkg::MT_WB)
					t = mtype_pkg::MT_WC;
			end
			mtype_pkg::MT_WT:
			begin
				if (p == mtype_pkg::MT_WC || p == mtype_pkg::MT_WP)
					t = p;
				else if (p == mtype_pkg::MT_WT || p == mtype_pkg::MT_WB)
					t = mtype_pkg::MT_WT;
			end
			mtype_pkg::MT_WB:
			begin
				if (p != mtype_pkg::MT_UC && p != mtype_pkg::MT_UCM)
					t = p;
			end
			mtype_pkg::MT_WP:
			begin
				if (p == mtype_pkg::MT_UCM || p == mtype_pkg::MT_WC)
					t = mtype_pkg::MT_WC;
				else if (p == mtype_pkg::MT_WT)
					t = mtype_pkg::MT_WT;
				else if (p == mtype_pkg::MT_WB || p == mtype_pkg::MT_WP)
					t = mtype_pkg::MT_WP;
			end
			default: t = mtype_pkg::MT_UC;
		endcase
		return t;
	endfunction

	function automatic word_t merge(input word_t old, input word_t nw, input logic [3:0] s);
		word_t m;
		for (int b = 0; b < 4; b++)
			m[8*b +: 8] = s[b] ? nw[8*b +: 8] : old[8*b +: 8];
		return m;
	endfunction

	// Range registers.
	word_t defType_q, defType_d;
	word_t fixed_q, fixed_d;
	word_t varBase_q [NVAR];
	word_t varBase_d [NVAR];
	word_t varMask_q [NVAR];
	word_t varMask_d [NVAR];
	mtype_pkg::resp_t last_q, last_d;

	// Range lookup on the request address.
	mtype_pkg::mem_type_t rangeType;
	mtype_pkg::mem_type_t varType;
	logic anyMatch, anyUc, sameType, onlyWtWb;
	always_comb
	begin
		anyMatch = 1'b0;
		anyUc = 1'b0;
		sameType = 1'b1;
		onlyWtWb = 1'b1;
		varType = mtype_pkg::MT_UC;
		for (int n = 0; n < NVAR; n++)
		begin
			if (varMask_q[n][`MT_MASK_VALID_BIT] &&
				((req.physAddr[31:`MT_PAGE_LSB] ^ varBase_q[n][31:`MT_PAGE_LSB]) &
				varMask_q[n][31:`MT_PAGE_LSB]) == '0)
			begin
				if (anyMatch && toType(varBase_q[n][2:0]) != varType)
					sameType = 1'b0;
				if (toType(varBase_q[n][2:0]) == mtype_pkg::MT_UC)
					anyUc = 1'b1;
				if (toType(varBase_q[n][2:0]) != mtype_pkg::MT_WT &&
					toType(varBase_q[n][2:0]) != mtype_pkg::MT_WB)
					onlyWtWb = 1'b0;
				if (!anyMatch)
					varType = toType(varBase_q[n][2:0]);
				anyMatch = 1'b1;
			end
		end
		if (!anyMatch || sameType)
			rangeType = varType;
		else if (anyUc)
			rangeType = mtype_pkg::MT_UC;
		else if (onlyWtWb)
			rangeType = mtype_pkg::MT_WT;
		else
			rangeType = mtype_pkg::MT_UC; // Undefined overlap, choose the safe type.
		if (!anyMatch)
			rangeType = toType(defType_q[2:0]);
		if (defType_q[`MT_DEF_FIXEN_BIT] && req.physAddr[31:`MT_FIXED_LIMIT_LSB] == '0)
			rangeType = toType(fixed_q[{req.physAddr[19:`MT_FIXED_SEL_LSB], 2'b00} +: 3]);
		if (!defType_q[`MT_DEF_EN_BIT] || !TYPING_SUPPORT)
			rangeType = mtype_pkg::MT_UC;
	end

	// Attribute index from the entry bits supplied by the walker.
	logic [2:0] patIdx;
	logic idxBit;
	always_comb
	begin
		idxBit = req.largePage ? req.entry[`PTE_PATBIG_BIT] : req.entry[`PTE_PAT4K_BIT];
		// Index bits for table fetches, from the PASID or pointing entry.
		patIdx = {1'b0, req.entry[`PTE_PCD_BIT], req.entry[`PTE_PWT_BIT]};
		if (req.kind == mtype_pkg::ACC_PAGE)
			patIdx[2] = idxBit;
	end

	// Request path: one registered stage.
	logic respValid_q, respValid_d;
	mtype_pkg::resp_t resp_q, resp_d;
	always_comb
	begin
		respValid_d = reqValid;
		resp_d = resp_q;
		last_d = last_q;
		if (reqValid)
		begin
			resp_d.applies = req.inDomain;
			resp_d.memType = mtype_pkg::MT_UC;
			if (req.inDomain && !req.cacheDisable)
			begin
				case (req.kind)
					mtype_pkg::ACC_CTX: resp_d.memType = mtype_pkg::MT_UC;
					mtype_pkg::ACC_PASID_TBL: resp_d.memType = rangeType;
					default: resp_d.memType = effType(rangeType, patType(req.page_attr_table, patIdx));
				endcase
			end
			last_d = resp_d;
		end
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			respValid_q <= 1'b0;
			resp_q <= '{applies: 1'b0, memType: mtype_pkg::MT_UC};
		end
		else
		begin
			respValid_q <= respValid_d;
			resp_q <= resp_d;
		end
	end
	assign respValid = respValid_q;
	assign resp = resp_q;

	// AXI4-Lite slave. Address and data are collected in either order.
	mtype_pkg::wr_state_t wrState_q, wrState_d;
	mtype_pkg::rd_state_t rdState_q, rdState_d;
	logic awHave_q, awHave_d, wHave_q, wHave_d;
	logic [7:0] awAddr_q, awAddr_d;
	word_t wData_q, wData_d;
	logic [3:0] wStrb_q, wStrb_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	word_t rdata_q, rdata_d;
	logic rdHit;
	word_t rdWord;

	assign awready = (wrState_q == mtype_pkg::WR_COLLECT) && !awHave_q;
	assign wready = (wrState_q == mtype_pkg::WR_COLLECT) && !wHave_q;
	assign arready = (rdState_q == mtype_pkg::RD_IDLE);

	always_comb
	begin
		rdHit = 1'b1;
		rdWord = '0;
		case (araddr)
			`MT_REG_CAP: rdWord = {20'h0_0000, 4'(NVAR), 7'h00, TYPING_SUPPORT};
			`MT_REG_DEFTYPE: rdWord = TYPING_SUPPORT ? defType_q : '0;
			`MT_REG_FIXED: rdWord = TYPING_SUPPORT ? fixed_q : '0;
			`MT_REG_LAST: rdWord = {28'h000_0000, last_q};
			default:
			begin
				rdHit = 1'b0;
				for (int n = 0; n < NVAR; n++)
				begin
					if (araddr == 8'(`MT_REG_VAR + n * `MT_VAR_STRIDE))
					begin
						rdHit = 1'b1;
						rdWord = TYPING_SUPPORT ? varBase_q[n] : '0;
					end
					if (araddr == 8'(`MT_REG_VAR + n * `MT_VAR_STRIDE + `MT_VAR_MASK_OFS))
					begin
						rdHit = 1'b1;
						rdWord = TYPING_SUPPORT ? varMask_q[n] : '0;
					end
				end
			end
		endcase
	end

	always_comb
	begin
		wrState_d = wrState_q;
		awHave_d = awHave_q;
		wHave_d = wHave_q;
		awAddr_d = awAddr_q;
		wData_d = wData_q;
		wStrb_d = wStrb_q;
		bresp_d = bresp_q;
		defType_d = defType_q;
		fixed_d = fixed_q;
		varBase_d = varBase_q;
		varMask_d = varMask_q;
		case (wrState_q)
			mtype_pkg::WR_COLLECT:
			begin
				if (awvalid && awready)
				begin
					awHave_d = 1'b1;
					awAddr_d = awaddr;
				end
				if (wvalid && wready)
				begin
					wHave_d = 1'b1;
					wData_d = wdata;
					wStrb_d = wstrb;
				end
				if (awHave_q && wHave_q)
				begin
					awHave_d = 1'b0;
					wHave_d = 1'b0;
					wrState_d = mtype_pkg::WR_RESP;
					bresp_d = `AXI_OKAY;
					if (!TYPING_SUPPORT)
						bresp_d = `AXI_OKAY;
					else if (awAddr_q == `MT_REG_DEFTYPE)
						defType_d = merge(defType_q, wData_q, wStrb_q);
					else if (awAddr_q == `MT_REG_FIXED)
						fixed_d = merge(fixed_q, wData_q, wStrb_q);
					else if (awAddr_q != `MT_REG_CAP && awAddr_q != `MT_REG_LAST)
					begin
						bresp_d = `AXI_SLVERR;
						for (int n = 0; n < NVAR; n++)
						begin
							if (awAddr_q == 8'(`MT_REG_VAR + n * `MT_VAR_STRIDE))
							begin
								varBase_d[n] = merge(varBase_q[n], wData_q, wStrb_q);
								bresp_d = `AXI_OKAY;
							end
							if (awAddr_q == 8'(`MT_REG_VAR + n * `MT_VAR_STRIDE + `MT_VAR_MASK_OFS))
							begin
								varMask_d[n] = merge(varMask_q[n], wData_q, wStrb_q);
								bresp_d = `AXI_OKAY;
							end
						end
					end
				end
			end
			mtype_pkg::WR_RESP:
			begin
				if (bready)
					wrState_d = mtype_pkg::WR_COLLECT;
			end
			default: wrState_d = mtype_pkg::WR_COLLECT;
		endcase
	end

	always_comb
	begin
		rdState_d = rdState_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		case (rdState_q)
			mtype_pkg::RD_IDLE:
			begin
				if (arvalid)
				begin
					rdState_d = mtype_pkg::RD_DATA;
					rdata_d = rdWord;
					rresp_d = rdHit ? `AXI_OKAY : `AXI_SLVERR;
				end
			end
			mtype_pkg::RD_DATA:
			begin
				if (rready)
					rdState_d = mtype_pkg::RD_IDLE;
			end
			default: rdState_d = mtype_pkg::RD_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrState_q <= mtype_pkg::WR_COLLECT;
			rdState_q <= mtype_pkg::RD_IDLE;
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			bresp_q <= `AXI_OKAY;
			rresp_q <= `AXI_OKAY;
			rdata_q <= 32'h0000_0000;
			defType_q <= `MT_DEFTYPE_RESET;
			fixed_q <= `MT_FIXED_RESET;
			last_q <= '{applies: 1'b0, memType: mtype_pkg::MT_UC};
			for (int n = 0; n < NVAR; n++)
			begin
				varBase_q[n] <= `MT_VAR_RESET;
				varMask_q[n] <= `MT_VAR_RESET;
			end
		end
		else
		begin
			wrState_q <= wrState_d;
			rdState_q <= rdState_d;
			awHave_q <= awHave_d;
			wHave_q <= wHave_d;
			awAddr_q <= awAddr_d;
			wData_q <= wData_d;
			wStrb_q <= wStrb_d;
			bresp_q <= bresp_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			defType_q <= defType_d;
			fixed_q <= fixed_d;
			last_q <= last_d;
			varBase_q <= varBase_d;
			varMask_q <= varMask_d;
		end
	end
	assign bvalid = (wrState_q == mtype_pkg::WR_RESP);
	assign bresp = bresp_q;
	assign rvalid = (rdState_q == mtype_pkg::RD_DATA);
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_typed;
		reqValid && req.inDomain && !req.cacheDisable;
	endsequence
	property p_outside;
		reqValid && !req.inDomain |=> respValid && !resp.applies;
	endproperty
	a_outside: assert property (p_outside) else $error("outside request typed");
	property p_cd;
		reqValid && req.inDomain && req.cacheDisable |=> resp.memType == mtype_pkg::MT_UC;
	endproperty
	a_cd: assert property (p_cd) else $error("cache disable not UC");
	property p_ctx;
		s_typed ##0 req.kind == mtype_pkg::ACC_CTX |=> resp.memType == mtype_pkg::MT_UC;
	endproperty
	a_ctx: assert property (p_ctx) else $error("context fetch not UC");
	property p_pasid;
		s_typed ##0 req.kind == mtype_pkg::ACC_PASID_TBL |=> resp.memType == $past(rangeType);
	endproperty
	a_pasid: assert property (p_pasid) else $error("pasid fetch not range type");
	property p_off;
		s_typed ##0 !defType_q[`MT_DEF_EN_BIT] ##0 req.kind == mtype_pkg::ACC_PASID_TBL
			|=> resp.memType == mtype_pkg::MT_UC;
	endproperty
	a_off: assert property (p_off) else $error("disabled ranges not UC");
	property p_wbpass;
		s_typed ##0 rangeType == mtype_pkg::MT_WB ##0 req.kind == mtype_pkg::ACC_PAGE
			##0 patType(req.page_attr_table, {idxBit, req.entry[4:3]}) == mtype_pkg::MT_WC
			|=> resp.memType == mtype_pkg::MT_WC;
	endproperty
	a_wbpass: assert property (p_wbpass) else $error("WB range did not pass WC");
	property p_bhold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rhold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_wresp;
		awHave_q && wHave_q |=> bvalid ##0 !awready [*1];
	endproperty
	a_wresp: assert property (p_wresp) else $error("write not answered");
endmodule

// >>> bench/walker_model.sv
module walker_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control from the bench
	input wire logic randOn,
	input wire logic dirValid,
	input wire mtype_pkg::req_t dirReq,
	// Requests towards the resolver
	output logic reqValid,
	output mtype_pkg::req_t req
);
	timeunit 1ns;
	timeprecision 1ns;
	integer seed = 32'hAE1C;
	logic [31:0] bases [7] = '{32'h0000_0000, 32'h000E_0000, 32'h0010_0000, 32'h0018_0000,
		32'h001A_0000, 32'h001C_0000, 32'h4000_0000};
	logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
	logic [31:0] rv;
	mtype_pkg::req_t r;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reqValid <= 1'b0;
			req <= '0;
		end
		else
		begin
			rv = $random(seed);
			r.inDomain = rv[0];
			r.cacheDisable = rv[3:1] == 3'h0;
			r.kind = mtype_pkg::access_kind_t'(rv[5:4]);
			r.largePage = rv[6];
			for (int i = 0; i < 8; i++)
				r.page_attr_table[4 * i +: 4] = {1'b0, codes[($random(seed) & 32'h7FFF_FFFF) % 6]};
			// The entry may come from the walker's own caches, so it can be stale.
			r.entry = {$random(seed), $random(seed)};
			r.physAddr = bases[rv[31:16] % 7] | ($random(seed) & 32'h0001_FFFF);
			// Random gaps keep the resolver seeing both sparse and back-to-back traffic.
			reqValid <= dirValid | (randOn & (rv[8:7] != 2'h0));
			req <= dirValid ? dirReq : r;
		end
	end
endmodule

// >>> bench/first_level_memory_type_resolver_tb_top.sv
module first_level_memory_type_resolver_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic randOn = 1'b0;
	logic dirValid = 1'b0;
	mtype_pkg::req_t dirReq = '0;
	mtype_pkg::req_t dq;
	logic reqValid;
	mtype_pkg::req_t req;
	logic respValid;
	mtype_pkg::resp_t resp;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	int err_count = 0;
	int tests_run = 0;
	logic hadReq = 1'b0;
	logic [31:0] mir [64] = '{default: 32'h0};
	logic [31:0] vr [8] = '{32'h0010_0004, 32'hFFF0_0800, 32'h0010_0006, 32'hFFF8_0800,
		32'h001C_0000, 32'hFFFC_0800, 32'h0018_0004, 32'hFFFE_0800};
	logic [31:0] dts [3] = '{32'h0000_0000, 32'h0000_0C06, 32'h0000_0806};
	mtype_pkg::resp_t expQ [$];

	walker_model walker (.clk(clk), .rst_n(rst_n), .randOn(randOn), .dirValid(dirValid),
		.dirReq(dirReq), .reqValid(reqValid), .req(req));
	first_level_memory_type_resolver #(.NVAR(4), .TYPING_SUPPORT(1'b1)) dut (.clk(clk),
		.rst_n(rst_n), .reqValid(reqValid), .req(req), .respValid(respValid), .resp(resp),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	initial
	begin
		forever #50 clk = ~clk;
	end

	function automatic mtype_pkg::mem_type_t toType(input logic [2:0] c);
		return (c == 3'h2 || c == 3'h3) ? mtype_pkg::MT_UC : mtype_pkg::mem_type_t'(c);
	endfunction

	function automatic mtype_pkg::mem_type_t rangeType(input logic [31:0] a);
		logic hit;
		mtype_pkg::mem_type_t r;
		mtype_pkg::mem_type_t t;
		hit = 1'b0;
		r = mtype_pkg::MT_UC;
		if (!mir[1][11])
			return mtype_pkg::MT_UC;
		if (mir[1][10] && a < 32'h0010_0000)
			return toType(mir[2][4 * a[19:17] +: 3]);
		for (int n = 0; n < 4; n++)
		begin
			t = toType(mir[8 + 2 * n][2:0]);
			if (mir[9 + 2 * n][11] && ((a ^ mir[8 + 2 * n]) & mir[9 + 2 * n] & 32'hFFFF_F000) == 0)
			begin
				if (!hit)
					r = t;
				else if (r == mtype_pkg::MT_UC || t == mtype_pkg::MT_UC)
					r = mtype_pkg::MT_UC;
				else if (r != t)
					r = (r inside {mtype_pkg::MT_WT, mtype_pkg::MT_WB} &&
						t inside {mtype_pkg::MT_WT, mtype_pkg::MT_WB}) ? mtype_pkg::MT_WT : mtype_pkg::MT_UC;
				hit = 1'b1;
			end
		end
		return hit ? r : toType(mir[1][2:0]);
	endfunction

	function automatic mtype_pkg::resp_t predict(input mtype_pkg::req_t q);
		mtype_pkg::resp_t e;
		mtype_pkg::mem_type_t p;
		mtype_pkg::mem_type_t r;
		logic [2:0] i;
		i = {q.kind == mtype_pkg::ACC_PAGE && (q.largePage ? q.entry[12] : q.entry[7]),
			q.entry[4], q.entry[3]};
		p = toType(q.page_attr_table[4 * i +: 3]);
		r = rangeType(q.physAddr);
		e.applies = q.inDomain;
		if (!q.inDomain || q.cacheDisable || q.kind == mtype_pkg::ACC_CTX)
			e.memType = mtype_pkg::MT_UC;
		else if (q.kind == mtype_pkg::ACC_PASID_TBL)
			e.memType = r;
		else
			case (r)
				mtype_pkg::MT_UC: e.memType = (p == mtype_pkg::MT_WC) ? p : mtype_pkg::MT_UC;
				mtype_pkg::MT_WC: e.memType = (p inside {mtype_pkg::MT_UC, mtype_pkg::MT_WT,
					mtype_pkg::MT_WP}) ? mtype_pkg::MT_UC : mtype_pkg::MT_WC;
				mtype_pkg::MT_WT: e.memType = (p inside {mtype_pkg::MT_UC, mtype_pkg::MT_UCM}) ?
					mtype_pkg::MT_UC : (p == mtype_pkg::MT_WB) ? mtype_pkg::MT_WT : p;
				mtype_pkg::MT_WB: e.memType = (p == mtype_pkg::MT_UCM) ? mtype_pkg::MT_UC : p;
				default: e.memType = (p == mtype_pkg::MT_UCM) ? mtype_pkg::MT_WC :
					(p == mtype_pkg::MT_WB) ? mtype_pkg::MT_WP : p;
			endcase
		return e;
	endfunction

	task automatic cmpResp(input mtype_pkg::resp_t exp, input mtype_pkg::resp_t got);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch resp expected %h seen %h", exp, got);
		end
	endtask

	task automatic cmpWord(input string what, input logic [33:0] exp, input logic [33:0] got);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic giveUp;
		err_count++;
		$display("mismatch handshake expected answer seen none");
		print_verdict();
	endtask

	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= !a[2];
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
				break;
			// Some writes hold off the response so that it must wait for bready.
			bready <= (n >= 2) || !a[2];
		end
		if (n == 50)
			giveUp();
		bready <= 1'b0;
		cmpWord("bresp", {er, 32'h0}, {bresp, 32'h0});
		if (er == 2'h0 && a != 8'h00)
			mir[a[7:2]] = d;
	endtask

	task automatic axiRead(input logic [7:0] a, input logic [33:0] exp);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= !a[2];
		for (n = 0; n < 50; n++)
		begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
				break;
			// Some reads hold off rready so that the read data must stand.
			rready <= (n >= 1) || !a[2];
		end
		if (n == 50)
			giveUp();
		rready <= 1'b0;
		cmpWord("read", exp, {rresp, rdata});
	endtask

	// Notes the expected answer for every request the resolver takes.
	always @(posedge clk)
	begin
		hadReq <= rst_n && reqValid;
		if (rst_n && reqValid)
			expQ.push_back(predict(req));
	end

	always @(posedge clk)
	begin
		if (rst_n)
			cmpWord("respValid", {33'h0, hadReq}, {33'h0, respValid});
		if (rst_n && respValid && expQ.size() > 0)
			cmpResp(expQ.pop_front(), resp);
	end

	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		axiRead(8'h00, {2'h0, 32'h0000_0401});
		axiRead(8'h04, {2'h0, 32'h0000_0000});
		axiWrite(8'h00, 32'hFFFF_FFFF, 2'h0);
		axiRead(8'h00, {2'h0, 32'h0000_0401});
		axiWrite(8'h10, 32'h0000_0001, 2'h2);
		axiRead(8'h10, {2'h2, 32'h0000_0000});
		for (int i = 0; i < 8; i++)
			axiWrite(8'h20 + 8'(4 * i), vr[i], 2'h0);
		axiWrite(8'h08, 32'h4605_6410, 2'h0);
		for (int k = 0; k < 3; k++)
		begin
			axiWrite(8'h04, dts[k], 2'h0);
			axiRead(8'h04, {2'h0, dts[k]});
			randOn <= 1'b1;
			repeat (400) @(posedge clk);
			randOn <= 1'b0;
			repeat (3) @(posedge clk);
		end
		// Every range type against every attribute type, large and small pages alternating within each range type.
		axiWrite(8'h04, 32'h0000_0C06, 2'h0);
		for (int r = 0; r < 5; r++)
			for (int p = 0; p < 6; p++)
			begin
				dq = '0;
				dq.inDomain = 1'b1;
				dq.page_attr_table = 32'h0056_4170;
				dq.kind = mtype_pkg::ACC_PAGE;
				dq.largePage = 1'((r + p) % 2);
				dq.entry[4] = 1'(p / 2 % 2);
				dq.entry[3] = 1'(p % 2);
				dq.entry[dq.largePage ? 12 : 7] = 1'(p / 4);
				dq.physAddr = 32'(r) << 17;
				@(posedge clk);
				dirValid <= 1'b1;
				dirReq <= dq;
			end
		@(posedge clk);
		dirValid <= 1'b0;
		repeat (3) @(posedge clk);
		axiRead(8'h0C, {2'h0, 32'h0000_000D});
		print_verdict();
	end
endmodule
